// ---- verilog/adc_setup_defs.svh ----
// Offsets, field positions, reset values and encodings of the analog setup registers.
`ifndef ADC_SETUP_DEFS_SVH
`define ADC_SETUP_DEFS_SVH
`define OFS_ANALOG_SETUP      2'h2
`define OFS_EXCITATION_ROUTE  2'h3
`define RST_ANALOG_SETUP      8'h00
`define RST_EXCITATION_ROUTE  8'h00
`define REF_SEL_MSB           7
`define REF_SEL_LSB           6
`define FILT_SEL_MSB          5
`define FILT_SEL_LSB          4
`define SWITCH_CTRL_BIT       3
`define CURRENT_MSB           2
`define CURRENT_LSB           0
`define ROUTE1_MSB            7
`define ROUTE1_LSB            5
`define ROUTE2_MSB            4
`define ROUTE2_LSB            2
`define READY_MODE_BIT        1
`define RATE_LOWEST           3'h0
`define OPMODE_NORMAL         2'h0
`define OPMODE_DUTY           2'h1
`define FRAME_BITS            16
`define LINK_IDLE             3'h2
`define MASK_ANALOG_SETUP     8'hFF
`define MASK_EXCITATION_ROUTE 8'hFE
`endif

// ---- verilog/adc_setup_pkg.sv ----
// Types shared by the analog setup register block.
package adc_setup_pkg;
  typedef logic [7:0] reg8_t;
  typedef enum logic [1:0] {REF_INTERNAL, REF_EXT_A, REF_EXT_B, REF_SUPPLY} ref_sel_e;
  typedef enum logic [1:0] {FILT_NONE, FILT_BOTH, FILT_50, FILT_60} filt_sel_e;
  typedef enum {LINK_CMD, LINK_DATA} link_state_e;
endpackage : adc_setup_pkg

// ---- verilog/adc_analog_setup_registers.sv ----
// Analog setup and excitation routing registers behind a mode 1 serial link.
// Summary of operation
// R01: Bits 7:6 select conversion reference source.
// R02: Bits 5:4 select mains rejection coefficients.
// R03: Filter choice applies only at the lowest rate, in normal or duty mode.
// R04: Bit 3 switch closes on start, opens sleep.
// R05: Bits 2:0 set both excitation current magnitudes.
// R06: Bits 7:5 route first excitation source.
// R07: Bits 4:2 route second excitation source.
// R08: Ready mode 0: dedicated ready output only.
// R09: Ready mode 1: ready on both outputs.
// R10: Serial link uses clock polarity 0, phase 1.
// R11: Clock idles low; data changes on rising.
// R12: Incoming bits sampled on falling clock edges.
// R13: Host writes zero to reserved bit 0.
// R14: Chip select high releases the combined pin.
// R15: Select low drives combined pin with ready state.
`timescale 1ns/1ps
`include "adc_setup_defs.svh"
module adc_analog_setup_registers (
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  input  wire logic                    sclk,
  input  wire logic                    csN,
  input  wire logic                    din,
  output logic                         combined_out_ready_pin_o,
  output logic                         combined_out_ready_pin_oe,
  output logic                         dedicated_ready_out_n,
  input  wire logic                    newDataEvent,
  input  wire logic [2:0]              dataRate,
  input  wire logic [1:0]              opMode,
  input  wire logic                    startCmd,
  input  wire logic                    sleep_cmd,
  output adc_setup_pkg::ref_sel_e      refSelect,
  output adc_setup_pkg::filt_sel_e     filterSelect,
  output logic                         filterActive,
  output logic                         low_side_switch_ctrl,
  output logic [2:0]                   excitation_current_level,
  output logic [2:0]                   first_source_route,
  output logic [2:0]                   second_source_route
);
  import adc_setup_pkg::*;

  localparam int LINK_PINS = 3;
  localparam int SCLK_IDX  = 2;
  localparam int CS_IDX    = 1;
  localparam int DIN_IDX   = 0;

  localparam int REG_COUNT = 2;
  localparam int SETUP_IDX = 0;
  localparam int ROUTE_IDX = 1;

  // Link pins pass two flops; only the second stage is read. The price is
  // two cycles of latency, which the slow link clock easily absorbs.
  wire  [LINK_PINS-1:0]      linkRaw;
  wire  [LINK_PINS-1:0]      linkIdle;
  wire  [LINK_PINS-1:0]      linkSync;
  logic                      sclkPrev;
  logic [15:0]               shiftIn;
  logic [4:0]                bitCount;
  reg8_t                     setupBank [REG_COUNT];
  wire  [REG_COUNT-1:0]      bankWrite;
  wire  [REG_COUNT-1:0][7:0] bankReset;
  wire  [REG_COUNT-1:0][7:0] bankMask;
  reg8_t                     analogSetup;
  reg8_t                     excitationRoute;
  logic                      outBit;
  logic                      dataPending;
  logic                      switchClosed;

  assign linkRaw  = {sclk, csN, din};
  assign linkIdle = `LINK_IDLE;

  for (genvar p = 0; p < LINK_PINS; p++)
  begin : gLinkSync
    logic stageOne;
    logic stageTwo;
    always_ff @(posedge clk_sys)
    begin
      if (!rstn)
      begin
        stageOne <= linkIdle[p];
        stageTwo <= linkIdle[p];
      end
      else
      begin
        stageOne <= linkRaw[p];
        stageTwo <= stageOne;
      end
    end
    assign linkSync[p] = stageTwo;
  end

  // Edges are found on the synchronised clock, so the link clock must stay
  // well below a quarter of the system clock.
  wire sclkS    = linkSync[SCLK_IDX];
  wire csS      = linkSync[CS_IDX];
  wire dinS     = linkSync[DIN_IDX];
  wire selected = !csS;
  wire riseEdge = selected && sclkS && !sclkPrev; // R11
  wire fallEdge = selected && !sclkS && sclkPrev; // R12

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      sclkPrev <= 1'b0;
    else
      sclkPrev <= sclkS;
  end

  // A frame is one address byte then one data byte; anything else is ignored.
  wire [15:0] frameWord     = {shiftIn[14:0], dinS};
  wire        lastBit       = (bitCount == 5'(`FRAME_BITS - 1));
  wire        frameDone     = fallEdge && lastBit; // R10
  wire [4:0]  next_bitCount = frameDone ? 5'h00 : bitCount + 5'h01;
  wire [7:0]  addrByte      = frameWord[15:8];
  wire [7:0]  dataByte      = frameWord[7:0];
  wire [1:0]  frameAddr     = addrByte[1:0];

  // A select release drops a partial frame, so a cut transfer writes nothing.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || csS)
    begin
      shiftIn  <= 16'h0000;
      bitCount <= 5'h00;
    end
    else if (fallEdge)
    begin
      shiftIn  <= frameWord; // R12
      bitCount <= next_bitCount;
    end
  end

  assign bankWrite[SETUP_IDX] = frameDone && (frameAddr == `OFS_ANALOG_SETUP);
  assign bankWrite[ROUTE_IDX] = frameDone && (frameAddr == `OFS_EXCITATION_ROUTE);
  assign bankReset[SETUP_IDX] = `RST_ANALOG_SETUP;
  assign bankReset[ROUTE_IDX] = `RST_EXCITATION_ROUTE;
  // The reserved routing bit is stored as zero, so a careless host cannot set it.
  assign bankMask[SETUP_IDX]  = `MASK_ANALOG_SETUP;
  assign bankMask[ROUTE_IDX]  = `MASK_EXCITATION_ROUTE;

  // Each register is one entry of a small flop bank, addressed by its index.
  for (genvar e = 0; e < REG_COUNT; e++)
  begin : gBank
    always_ff @(posedge clk_sys)
    begin
      if (!rstn)
        setupBank[e] <= bankReset[e];
      else if (bankWrite[e])
        setupBank[e] <= dataByte & bankMask[e];
    end
  end

  assign analogSetup     = setupBank[SETUP_IDX];
  assign excitationRoute = setupBank[ROUTE_IDX];

  // Field decode of the two registers.
  wire [1:0] refField      = analogSetup[`REF_SEL_MSB:`REF_SEL_LSB];
  wire [1:0] filtField     = analogSetup[`FILT_SEL_MSB:`FILT_SEL_LSB];
  wire       switchEnabled = analogSetup[`SWITCH_CTRL_BIT];
  wire [2:0] currentField  = analogSetup[`CURRENT_MSB:`CURRENT_LSB];
  wire [2:0] route1Field   = excitationRoute[`ROUTE1_MSB:`ROUTE1_LSB];
  wire [2:0] route2Field   = excitationRoute[`ROUTE2_MSB:`ROUTE2_LSB];
  wire       readyMode     = excitationRoute[`READY_MODE_BIT];

  // The filter choice reaches the modulator only at the lowest rate, in normal or duty mode.
  wire rateLowest = (dataRate == `RATE_LOWEST);
  wire modeNormal = (opMode == `OPMODE_NORMAL);
  wire modeDuty   = (opMode == `OPMODE_DUTY);
  wire lowRate    = rateLowest && (modeNormal || modeDuty); // R03

  assign refSelect                = ref_sel_e'(refField); // R01
  assign filterSelect             = lowRate ? filt_sel_e'(filtField) : FILT_NONE; // R02 R03
  assign filterActive             = lowRate; // R03
  assign excitation_current_level = currentField; // R05
  assign first_source_route       = route1Field; // R06
  assign second_source_route      = route2Field; // R07
  assign low_side_switch_ctrl     = switchClosed; // R04

  // Switch follows commands only while enabled; clearing the bit opens it on the next clock.
  wire next_switchClosed = !switchEnabled ? 1'b0 :
                           sleep_cmd      ? 1'b0 :
                           startCmd       ? 1'b1 :
                                            switchClosed; // R04
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      switchClosed <= 1'b0;
    else
      switchClosed <= next_switchClosed; // R04
  end

  // New data wins over the clear that a completed frame applies.
  wire next_dataPending = newDataEvent ? 1'b1 : (frameDone ? 1'b0 : dataPending);
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      dataPending <= 1'b0;
    else
      dataPending <= next_dataPending;
  end

  // The dedicated output is driven whether or not the host selects the device.
  assign dedicated_ready_out_n = !dataPending; // R08 R09

  // Until the first rising clock of a frame the out bit tracks the ready state,
  // so a polling host sees it in the very cycle that select is seen low.
  wire holdReady = csS || (bitCount == 5'h00 && !sclkS && !sclkPrev); // R15
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      outBit <= 1'b1;
    else if (holdReady)
      outBit <= !next_dataPending; // R15
    else if (riseEdge)
      outBit <= 1'b1; // R11
  end

  // The pin is released outside selection so that other devices may share it.
  assign combined_out_ready_pin_o  = outBit;
  assign combined_out_ready_pin_oe = selected && readyMode; // R08 R09 R14
endmodule : adc_analog_setup_registers

// ---- bench/adc_setup_chk.sv ----
// Checker for the analog setup register block.
`timescale 1ns/1ps
module adc_setup_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic csN,
  input wire logic newDataEvent,
  input wire logic startCmd,
  input wire logic sleep_cmd,
  input wire logic [2:0] dataRate,
  input wire logic [1:0] opMode,
  input adc_setup_pkg::filt_sel_e filterSelect,
  input wire logic filterActive,
  input wire logic low_side_switch_ctrl,
  input wire logic combined_out_ready_pin_o,
  input wire logic combined_out_ready_pin_oe,
  input wire logic dedicated_ready_out_n
);
  import adc_setup_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_ready_set: assert property (newDataEvent |=> !dedicated_ready_out_n)
    else $error("ready not raised");
  chk_ready_cause: assert property ($fell(dedicated_ready_out_n) |-> $past(newDataEvent))
    else $error("ready without event");
  chk_pin_release: assert property (csN [*4] |-> !combined_out_ready_pin_oe)
    else $error("pin driven while deselected");
  chk_pin_value: assert property ($rose(combined_out_ready_pin_oe)
    |-> combined_out_ready_pin_o == dedicated_ready_out_n)
    else $error("pin level wrong");
  chk_filter_gate: assert property (filterActive == (dataRate == 3'h0 && opMode < 2'h2))
    else $error("filter gate wrong");
  chk_filter_off: assert property (!filterActive |-> filterSelect == FILT_NONE)
    else $error("filter leaks");
  chk_sleep_opens: assert property (sleep_cmd |=> !low_side_switch_ctrl)
    else $error("switch not opened");
  chk_switch_cause: assert property ($rose(low_side_switch_ctrl) |-> $past(startCmd))
    else $error("switch closed alone");
  cover property (newDataEvent);
  cover property ($rose(combined_out_ready_pin_oe));
  cover property ($rose(low_side_switch_ctrl));
endmodule : adc_setup_chk
bind adc_analog_setup_registers adc_setup_chk adc_setup_chk_inst (.*);

// ---- bench/host_spi_model.sv ----
// Host serial master model for the setup register link.
`timescale 1ns/1ps
module host_spi_model (
  output logic sclk = 1'b0,
  output logic csN = 1'b1,
  output logic din = 1'b0
);
  task automatic sel(input logic v);
    csN = v;
    #400;
  endtask : sel
  // A released data line shows the inverse, since no pull holds it.
  task automatic frame(input logic [15:0] w);
    sel(1'b0);
    for (int i = 15; i >= 0; i--)
    begin
      sclk = 1'b1;
      din = w[i];
      #160 sclk = 1'b0;
      #160;
    end
    din = ~din;
    sel(1'b1);
  endtask : frame
endmodule : host_spi_model

// ---- bench/adc_analog_setup_registers_tb.sv ----
// Self-checking bench for the analog setup register block.
`timescale 1ns/1ps
module adc_analog_setup_registers_tb;
  import adc_setup_pkg::*;
  logic clk_sys = 0, rstn = 0, newDataEvent = 0, startCmd = 0, sleep_cmd = 0;
  logic [2:0] dataRate = 0;
  logic [1:0] opMode = 0;
  wire sclk, csN, din, pinO, pinOe, readyN, active, sw;
  wire [2:0] level, route1, route2;
  ref_sel_e refSel;
  filt_sel_e filtSel;
  int miscompares = 0, checks = 0, seed = 97, fa;
  int mreg[4];
  always #20 clk_sys = ~clk_sys;
  host_spi_model host_spi_model_inst (.sclk(sclk), .csN(csN), .din(din));
  adc_analog_setup_registers adc_analog_setup_registers_inst (.clk_sys(clk_sys),
    .rstn(rstn), .sclk(sclk), .csN(csN), .din(din), .combined_out_ready_pin_o(pinO),
    .combined_out_ready_pin_oe(pinOe), .dedicated_ready_out_n(readyN),
    .newDataEvent(newDataEvent), .dataRate(dataRate), .opMode(opMode),
    .startCmd(startCmd), .sleep_cmd(sleep_cmd), .refSelect(refSel),
    .filterSelect(filtSel), .filterActive(active), .low_side_switch_ctrl(sw),
    .excitation_current_level(level), .first_source_route(route1),
    .second_source_route(route2));
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic check_all;
    fa = (dataRate == 0 && opMode < 2);
    cmp("ref", 8'(mreg[2] >> 6), refSel);
    cmp("act", 8'(fa), active);
    cmp("filt", fa ? 8'((mreg[2] >> 4) & 3) : 8'h00, filtSel);
    cmp("level", 8'(mreg[2] & 7), level);
    cmp("route1", 8'(mreg[3] >> 5), route1);
    cmp("route2", 8'((mreg[3] >> 2) & 7), route2);
  endtask : check_all
  // Frames to offsets 0 and 1 must leave both registers alone.
  task automatic wr(input int a, input int d);
    host_spi_model_inst.frame({8'(a), 8'(d)});
    if (a > 1)
      mreg[a] = d;
  endtask : wr
  task automatic pulse(ref logic s);
    @(posedge clk_sys) #1 s = 1;
    @(posedge clk_sys) #1 s = 0;
  endtask : pulse
  task automatic tally_and_finish;
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #1000000 miscompares++;
    tally_and_finish();
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1 rstn = 1;
    repeat (3) @(posedge clk_sys);
    check_all();
    cmp("rdy", 1, readyN);
    repeat (8)
    begin
      @(posedge clk_sys) #1 dataRate = 3'($random(seed)) & 3'h3;
      opMode = 2'($random(seed)) % 2'h3;
      wr(2, $random(seed) & 255);
      wr(3, $random(seed) & 252);
      wr(1, $random(seed));
      check_all();
    end
    host_spi_model_inst.sel(0);
    cmp("oe", 0, pinOe);
    host_spi_model_inst.sel(1);
    wr(3, 2);
    pulse(newDataEvent);
    cmp("rdy", 0, readyN);
    host_spi_model_inst.sel(0);
    cmp("oe", 1, pinOe);
    cmp("pin", 0, pinO);
    host_spi_model_inst.sel(1);
    cmp("oe", 0, pinOe);
    wr(2, 8);
    cmp("rdy", 1, readyN);
    host_spi_model_inst.sel(0);
    cmp("pin", 1, pinO);
    host_spi_model_inst.sel(1);
    pulse(startCmd);
    cmp("sw", 1, sw);
    pulse(sleep_cmd);
    cmp("sw", 0, sw);
    tally_and_finish();
  end
endmodule : adc_analog_setup_registers_tb
